// ### verilog/srap_pkg.sv
// Shared constants and types of the serial register access port.
// Assumes both ends, the checker and the bench import it whole.
package srap_pkg;

   // ************************************************************
   // Word layout
   // ************************************************************
   localparam int          WORD_W       = 16;
   localparam int          ADDR_W       = 10;
   localparam int          CNT_W        = 4;
   localparam int          DEPTH        = 1024;
   localparam int          PAT_HI       = 15;
   localparam int          PAT_LO       = 11;
   localparam int          RW_BIT       = 10;
   localparam logic [4:0]  ENABLE_PAT   = 5'h1C;
   localparam logic [ADDR_W-1:0] ADDR_MAX = 10'h3FF;
   localparam logic [CNT_W-1:0]  LAST_BIT = 4'hF;

   // ************************************************************
   // Two-wire variant slave address
   // ************************************************************
   localparam logic [4:0]  I2C_ADDR_BASE = 5'h0B;

   // ************************************************************
   // Host timing: half a link clock period in clock_i cycles
   // ************************************************************
   localparam int          HALF_W       = 3;
   localparam logic [HALF_W-1:0] HALF_LAST = 3'h3;
   localparam int          COUNT_W      = 8;

   // ************************************************************
   // State types
   // ************************************************************
   typedef enum logic [1:0] {DEV_CMD, DEV_WRITE, DEV_READ, DEV_IGNORE} srap_dev_state_e;
   typedef enum logic [1:0] {HST_IDLE, HST_LOW, HST_HIGH, HST_END} srap_hst_state_e;

endpackage

// ### verilog/srap_if.sv
// Four-wire link between the port's device end and its host end.
// Assumes the bench ties the two ends together through this interface only.
`timescale 1ns/1ns
`default_nettype none
interface srap_if;
   logic sclk;
   logic cs_n;
   logic sdi;
   logic sdo_val;
   logic sdo_oe_n;
   wire  sdo;

   // ************************************************************
   // Released serial output
   // ************************************************************
   // The device only shows release through sdo_oe_n; the line then
   // carries the inverse of the last bit, so a stray sample shows up
   assign sdo = sdo_oe_n ? ~sdo_val : sdo_val;

   modport dev  (input sclk, input cs_n, input sdi, output sdo_val, output sdo_oe_n);
   modport host (output sclk, output cs_n, output sdi, input sdo);
endinterface
`default_nettype wire

// ### verilog/srap_sync2.sv
// Two flip-flop level synchroniser, WIDTH bits wide.
// Assumes each bit changes slowly against clock_i; no word coherence.
`timescale 1ns/1ns
`default_nettype none
module srap_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             clock_i,
   input  wire logic             rst_n_i,
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         meta_reg <= '0;
         q_o      <= '0;
      end
      else
      begin
         meta_reg <= d_i;
         q_o      <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// ### verilog/srap_dev.sv
// Device end of the serial register access port: four-wire slave,
// register image, write notification towards the core clock domain.
// Assumes the host end drives sclk, cs_n and sdi through srap_if.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// [R1] Sample on rising, change output on falling
// [R2] Master opens with chip select fall, command
// [R3] Command bits 15..11 must be 11100
// [R4] Bit 10 set means read, clear write
// [R5] Low ten command bits load address pointer
// [R6] Write data words stored at pointer
// [R7] Pointer advances after each written word
// [R8] Writes stop at maximum; no wrap, discard
// [R9] Single write is 32 bits under select
// [R10] Clock may idle high or low
// [R11] Sixteen pulses shift out one word
// [R12] First read bit on first following fall
// [R13] Pointer advances after each read word
// [R14] Chip select high ends the transaction
// [R15] At maximum, repeat last register on reads
// [R16] Output high impedance unless reading; srap_if drives the inverse of sdo_val instead of floating
// [R17] Two-wire variant is slave only
// [R18] Two-wire address 01011 plus two straps
// [R19] Every register is 16 bits wide
// [R20] Bad enable pattern: ignore until deselect
module srap_dev
   import srap_pkg::*;
(
   input  wire logic              clock_i,
   input  wire logic              rst_n_i,
   srap_if.dev                    link,
   input  wire logic              slave_addr_strap_lo_i,
   input  wire logic              slave_addr_strap_hi_i,
   output logic      [6:0]        i2c_slave_addr_o,
   output logic                   wr_valid_o,
   output logic      [ADDR_W-1:0] wr_addr_o,
   output logic      [WORD_W-1:0] wr_data_o
);

   // ************************************************************
   // Link side state, clocked by the host's serial clock
   // ************************************************************
   srap_dev_state_e   state_reg;
   logic [CNT_W-1:0]  cnt_reg;
   logic [WORD_W-1:0] shift_reg;
   logic [WORD_W-1:0] shift_next;
   logic [ADDR_W-1:0] ptr_reg;
   logic              full_reg;
   logic [WORD_W-1:0] rd_word_reg;
   logic              word_done;
   logic              store_word;
   logic              link_rst_n;
   logic [WORD_W-1:0] mem [DEPTH];

   // Holding registers for the core; not cleared by deselect, so the
   // toggle never flips on its own when chip select rises
   logic [ADDR_W-1:0] hold_addr_reg;
   logic [WORD_W-1:0] hold_data_reg;
   logic              wr_tgl_reg;

   // Deselect acts as asynchronous reset: the link clock may stop at
   // any level once cs_n rises, so no edge can be counted on to finish
   assign link_rst_n = rst_n_i & ~link.cs_n;                  // see [R14] see [R10]
   assign shift_next = {shift_reg[WORD_W-2:0], link.sdi};
   assign word_done  = (cnt_reg == LAST_BIT);
   assign store_word = (state_reg == DEV_WRITE) && word_done && !full_reg;

   // ************************************************************
   // Command decode, pointer and bit counter (rising edge)
   // ************************************************************
   always_ff @(posedge link.sclk or negedge link_rst_n)       // see [R1] see [R2]
   begin
      if (!link_rst_n)
      begin
         state_reg   <= DEV_CMD;
         cnt_reg     <= '0;
         shift_reg   <= '0;
         ptr_reg     <= '0;
         full_reg    <= 1'b0;
         rd_word_reg <= '0;
      end
      else
      begin
         cnt_reg   <= cnt_reg + 4'h1;                         // see [R19]
         shift_reg <= shift_next;
         unique case (state_reg)
            DEV_CMD:
            begin
               if (word_done)
               begin
                  if (shift_next[PAT_HI:PAT_LO] == ENABLE_PAT)  // see [R3]
                  begin
                     ptr_reg <= shift_next[ADDR_W-1:0];         // see [R5]
                     if (shift_next[RW_BIT])                    // see [R4]
                     begin
                        state_reg   <= DEV_READ;
                        rd_word_reg <= mem[shift_next[ADDR_W-1:0]];
                     end
                     else
                     begin
                        state_reg <= DEV_WRITE;
                     end
                  end
                  else
                  begin
                     state_reg <= DEV_IGNORE;                   // see [R20]
                  end
               end
            end
            DEV_WRITE:
            begin
               if (store_word)
               begin
                  if (ptr_reg == ADDR_MAX)
                  begin
                     full_reg <= 1'b1;                          // see [R8]
                  end
                  else
                  begin
                     ptr_reg <= ptr_reg + 10'h001;              // see [R7]
                  end
               end
            end
            DEV_READ:
            begin
               if (word_done)
               begin
                  if (ptr_reg == ADDR_MAX)
                  begin
                     rd_word_reg <= mem[ptr_reg];               // see [R15]
                  end
                  else
                  begin
                     ptr_reg     <= ptr_reg + 10'h001;          // see [R13]
                     rd_word_reg <= mem[ptr_reg + 10'h001];
                  end
               end
            end
            DEV_IGNORE:
            begin
               // Nothing until deselect clears the state
            end
         endcase
      end
   end

   // ************************************************************
   // Register image
   // ************************************************************
   // A full word lands only on its sixteenth bit, so a host that stops
   // short of 32 bits leaves the register untouched
   always_ff @(posedge link.sclk)
   begin
      if (store_word)
      begin
         mem[ptr_reg] <= shift_next;                            // see [R6] see [R9]
      end
   end

   always_ff @(posedge link.sclk or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         hold_addr_reg <= '0;
         hold_data_reg <= '0;
         wr_tgl_reg    <= 1'b0;
      end
      else if (store_word)
      begin
         hold_addr_reg <= ptr_reg;
         hold_data_reg <= shift_next;
         wr_tgl_reg    <= ~wr_tgl_reg;
      end
   end

   // ************************************************************
   // Serial output (falling edge)
   // ************************************************************
   // The bit for the next rising edge is chosen by the count the
   // rising edge just left, so bit 15 leaves on the first fall after
   // the command
   always_ff @(negedge link.sclk or negedge link_rst_n)      // see [R1]
   begin
      if (!link_rst_n)
      begin
         link.sdo_val  <= 1'b0;
         link.sdo_oe_n <= 1'b1;                                 // see [R16]
      end
      else
      begin
         link.sdo_val  <= rd_word_reg[~cnt_reg];                // see [R12] see [R11]
         link.sdo_oe_n <= (state_reg != DEV_READ);              // see [R16] see [R20]
      end
   end

   // ************************************************************
   // Core clock domain: write notification and strap address
   // ************************************************************
   logic       tgl_sync;
   logic       tgl_seen_reg;
   logic [1:0] strap_sync;

   srap_sync2 #(.WIDTH(1)) u_tgl_sync (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .d_i     (wr_tgl_reg),
      .q_o     (tgl_sync)
   );

   srap_sync2 #(.WIDTH(2)) u_strap_sync (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .d_i     ({slave_addr_strap_hi_i, slave_addr_strap_lo_i}),
      .q_o     (strap_sync)
   );

   // Hold registers stay still for a whole word (16 link clocks),
   // far longer than the synchroniser needs
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         tgl_seen_reg <= 1'b0;
         wr_valid_o   <= 1'b0;
         wr_addr_o    <= '0;
         wr_data_o    <= '0;
      end
      else
      begin
         tgl_seen_reg <= tgl_sync;
         wr_valid_o   <= tgl_sync ^ tgl_seen_reg;
         if (tgl_sync ^ tgl_seen_reg)
         begin
            wr_addr_o <= hold_addr_reg;
            wr_data_o <= hold_data_reg;
         end
      end
   end

   // Address only; this end never drives the two-wire bus
   always_ff @(posedge clock_i or negedge rst_n_i)            // see [R17]
   begin
      if (!rst_n_i)
      begin
         i2c_slave_addr_o <= {I2C_ADDR_BASE, 2'h0};
      end
      else
      begin
         i2c_slave_addr_o <= {I2C_ADDR_BASE, strap_sync};       // see [R18]
      end
   end

endmodule
`default_nettype wire

// ### verilog/srap_host.sv
// Host end of the serial register access port: four-wire master.
// Assumes a single clock_i domain; the serial clock is divided from it.
`timescale 1ns/1ns
`default_nettype none
module srap_host
   import srap_pkg::*;
(
   input  wire logic               clock_i,
   input  wire logic               rst_n_i,
   srap_if.host                    link,
   input  wire logic               cmd_valid_i,
   output logic                    cmd_ready_o,
   input  wire logic               cmd_read_i,
   input  wire logic [ADDR_W-1:0]  cmd_addr_i,
   input  wire logic [COUNT_W-1:0] cmd_count_i,
   input  wire logic               wr_valid_i,
   output logic                    wr_ready_o,
   input  wire logic [WORD_W-1:0]  wr_data_i,
   output logic                    rd_valid_o,
   output logic      [WORD_W-1:0]  rd_data_o
);

   srap_hst_state_e    state_reg;
   logic [HALF_W-1:0]  div_reg;
   logic [CNT_W-1:0]   bit_reg;
   logic [COUNT_W-1:0] left_reg;
   logic               read_reg;
   logic               in_cmd_reg;
   logic               need_data_reg;
   logic [WORD_W-1:0]  tx_reg;
   logic [WORD_W-1:0]  rx_reg;
   logic               sdo_sync;
   logic               half_done;

   // Serial input comes from the far clock domain
   srap_sync2 #(.WIDTH(1)) u_sdo_sync (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .d_i     (link.sdo),
      .q_o     (sdo_sync)
   );

   assign half_done   = (div_reg == HALF_LAST);
   assign cmd_ready_o = (state_reg == HST_IDLE);
   assign wr_ready_o  = (state_reg == HST_LOW) && need_data_reg;
   assign link.sdi    = tx_reg[WORD_W-1];

   // ************************************************************
   // Frame sequencer
   // ************************************************************
   // Four clock_i cycles per half period leave room for the two-stage
   // synchroniser before each rising-edge sample
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_reg     <= HST_IDLE;
         div_reg       <= '0;
         bit_reg       <= '0;
         left_reg      <= '0;
         read_reg      <= 1'b0;
         in_cmd_reg    <= 1'b0;
         need_data_reg <= 1'b0;
         tx_reg        <= '0;
         rx_reg        <= '0;
         link.sclk     <= 1'b0;
         link.cs_n     <= 1'b1;
         rd_valid_o    <= 1'b0;
         rd_data_o     <= '0;
      end
      else
      begin
         rd_valid_o <= 1'b0;
         unique case (state_reg)
            HST_IDLE:
            begin
               if (cmd_valid_i)
               begin
                  tx_reg     <= {ENABLE_PAT, cmd_read_i, cmd_addr_i};   // see [R3]
                  read_reg   <= cmd_read_i;
                  left_reg   <= cmd_count_i;
                  in_cmd_reg <= 1'b1;
                  bit_reg    <= '0;
                  div_reg    <= '0;
                  link.cs_n  <= 1'b0;                                   // see [R2]
                  state_reg  <= HST_LOW;
               end
            end
            HST_LOW:
            begin
               if (need_data_reg)
               begin
                  if (wr_valid_i)
                  begin
                     tx_reg        <= wr_data_i;                        // see [R6]
                     need_data_reg <= 1'b0;
                     div_reg       <= '0;
                  end
               end
               else if (half_done)
               begin
                  div_reg   <= '0;
                  link.sclk <= 1'b1;                                    // see [R1]
                  rx_reg    <= {rx_reg[WORD_W-2:0], sdo_sync};
                  state_reg <= HST_HIGH;
               end
               else
               begin
                  div_reg <= div_reg + 3'h1;
               end
            end
            HST_HIGH:
            begin
               if (half_done)
               begin
                  div_reg   <= '0;
                  link.sclk <= 1'b0;
                  tx_reg    <= {tx_reg[WORD_W-2:0], 1'b0};
                  bit_reg   <= bit_reg + 4'h1;
                  state_reg <= HST_LOW;
                  if (bit_reg == LAST_BIT)
                  begin
                     in_cmd_reg <= 1'b0;
                     if (!in_cmd_reg)
                     begin
                        left_reg   <= left_reg - 8'h01;
                        rd_valid_o <= read_reg;                         // see [R11]
                        rd_data_o  <= rx_reg;
                     end
                     if (!in_cmd_reg && left_reg == 8'h01)
                     begin
                        state_reg <= HST_END;
                     end
                     else
                     begin
                        need_data_reg <= !read_reg;                     // see [R9]
                     end
                  end
               end
               else
               begin
                  div_reg <= div_reg + 3'h1;
               end
            end
            HST_END:
            begin
               if (half_done)
               begin
                  div_reg   <= '0;
                  link.cs_n <= 1'b1;                                    // see [R14]
                  state_reg <= HST_IDLE;
               end
               else
               begin
                  div_reg <= div_reg + 3'h1;
               end
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// ### bench/srap_link_asserts.sv
// Checker for the four-wire link between the host and device ends.
// Assumes it is instantiated beside srap_if, sampling on clock_i.
`timescale 1ns/1ns
`default_nettype none
module srap_link_asserts
   import srap_pkg::*;
(
   input  wire logic clock_i,
   input  wire logic rst_n_i,
   input  wire logic sclk,
   input  wire logic cs_n,
   input  wire logic sdi,
   input  wire logic sdo_val,
   input  wire logic sdo_oe_n
);
   // ************************************************************
   // Frame tracking
   // ************************************************************
   logic        sclk_q;
   logic        rise;
   logic [12:0] rise_cnt;
   logic [15:0] shift_q;
   logic [15:0] cmd_q;

   // Oversampled: the link clock is far slower than clock_i
   assign rise = sclk & ~sclk_q;

   always_ff @(posedge clock_i or negedge rst_n_i)
      if (!rst_n_i)
         sclk_q <= 1'b0;
      else
         sclk_q <= sclk;

   always_ff @(posedge clock_i or negedge rst_n_i)
      if (!rst_n_i)
         rise_cnt <= 13'h0000;
      else if (cs_n)
         rise_cnt <= 13'h0000;
      else if (rise)
         rise_cnt <= rise_cnt + 13'h0001;

   always_ff @(posedge clock_i or negedge rst_n_i)
      if (!rst_n_i)
         shift_q <= 16'h0000;
      else if (rise)
         shift_q <= {shift_q[14:0], sdi};

   always_ff @(posedge clock_i or negedge rst_n_i)
      if (!rst_n_i)
         cmd_q <= 16'h0000;
      else if (rise && rise_cnt == 13'h000F)
         cmd_q <= {shift_q[14:0], sdi};

   // ************************************************************
   // Properties
   // ************************************************************
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   property p_idle_float; cs_n |-> sdo_oe_n; endproperty
   a_idle_float: assert property (p_idle_float) else $error("sdo driven while idle");
   property p_idle_clock; cs_n |-> !sclk; endproperty
   a_idle_clock: assert property (p_idle_clock) else $error("sclk high while idle");
   property p_sdi_hold; (!cs_n && sclk && $past(sclk)) |-> $stable(sdi); endproperty
   a_sdi_hold: assert property (p_sdi_hold) else $error("sdi moved while sclk high");
   property p_sdo_on_fall;
      (!sdo_oe_n && !$past(sdo_oe_n) && $changed(sdo_val)) |-> $fell(sclk);
   endproperty
   a_sdo_on_fall: assert property (p_sdo_on_fall) else $error("sdo moved off a fall");
   property p_enable_pattern; (rise_cnt == 13'h0010) |-> cmd_q[15:11] == ENABLE_PAT; endproperty
   a_enable_pattern: assert property (p_enable_pattern) else $error("bad enable field");
   property p_frame_whole;
      $rose(cs_n) |-> rise_cnt[3:0] == 4'h0 && rise_cnt >= 13'h0020;
   endproperty
   a_frame_whole: assert property (p_frame_whole) else $error("frame not whole words");
   property p_write_quiet;
      (!cs_n && rise_cnt >= 13'h0010 && !cmd_q[RW_BIT]) |-> sdo_oe_n;
   endproperty
   a_write_quiet: assert property (p_write_quiet) else $error("sdo driven in write");
   property p_first_bit;
      (!cs_n && rise_cnt == 13'h0010 && cmd_q[RW_BIT] && $fell(sclk)) |-> !sdo_oe_n;
   endproperty
   a_first_bit: assert property (p_first_bit) else $error("first read bit late");
   property p_read_drive;
      (!cs_n && rise_cnt > 13'h0010 && cmd_q[RW_BIT]) |-> !sdo_oe_n;
   endproperty
   a_read_drive: assert property (p_read_drive) else $error("sdo released in read");
endmodule
`default_nettype wire

// ### bench/tb.sv
// Bench joining the host and device ends of the port over srap_if.
// Assumes srap_pkg, srap_if, both ends and the checker are compiled.
`timescale 1ns/1ns
`default_nettype none
module tb import srap_pkg::*;;
   logic               clock_i;
   logic               rst_n_i;
   logic               cmd_valid_i;
   logic               cmd_read_i;
   logic [ADDR_W-1:0]  cmd_addr_i;
   logic [COUNT_W-1:0] cmd_count_i;
   logic               wr_valid_i;
   logic [WORD_W-1:0]  wr_data_i;
   logic               strap_lo;
   logic               strap_hi;
   logic               cmd_ready;
   logic               wr_ready;
   logic               rd_valid;
   logic [WORD_W-1:0]  rd_data;
   logic [6:0]         i2c_addr;
   logic               dv;
   logic [ADDR_W-1:0]  da;
   logic [WORD_W-1:0]  dd;
   int                 n_mismatch;
   int                 total_checks;
   logic [WORD_W-1:0]  mem [int];
   logic [31:0]        exp_q [$];
   logic [31:0]        got_q [$];

   srap_if i_srap_if ();
   srap_dev i_srap_dev (.clock_i(clock_i), .rst_n_i(rst_n_i), .link(i_srap_if.dev),
      .slave_addr_strap_lo_i(strap_lo), .slave_addr_strap_hi_i(strap_hi),
      .i2c_slave_addr_o(i2c_addr), .wr_valid_o(dv), .wr_addr_o(da), .wr_data_o(dd));
   srap_host i_srap_host (.clock_i(clock_i), .rst_n_i(rst_n_i), .link(i_srap_if.host),
      .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready), .cmd_read_i(cmd_read_i),
      .cmd_addr_i(cmd_addr_i), .cmd_count_i(cmd_count_i), .wr_valid_i(wr_valid_i),
      .wr_ready_o(wr_ready), .wr_data_i(wr_data_i), .rd_valid_o(rd_valid),
      .rd_data_o(rd_data));
   srap_link_asserts i_srap_link_asserts (.clock_i(clock_i), .rst_n_i(rst_n_i),
      .sclk(i_srap_if.sclk), .cs_n(i_srap_if.cs_n), .sdi(i_srap_if.sdi),
      .sdo_val(i_srap_if.sdo_val), .sdo_oe_n(i_srap_if.sdo_oe_n));

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic send_cmd(input logic rd, input int a, input int n);
      @(posedge clock_i);
      cmd_valid_i <= 1'b1;
      cmd_read_i <= rd;
      cmd_addr_i <= ADDR_W'(a);
      cmd_count_i <= COUNT_W'(n);
      do @(negedge clock_i); while (cmd_ready !== 1'b1);
      @(posedge clock_i);
      cmd_valid_i <= 1'b0;
   endtask

   // Waits out the frame and the core-side pulse lag of up to four cycles
   task automatic end_frame();
      do @(negedge clock_i); while (cmd_ready !== 1'b1);
      repeat (8) @(negedge clock_i);
      chk({31'h0, i_srap_if.sdo_oe_n}, {31'h0, 1'b1});
   endtask

   task automatic do_write(input int a, input int n);
      logic [WORD_W-1:0] wd;
      send_cmd(1'b0, a, n);
      for (int i = 0; i < n; i++)
      begin
         wd = 16'hC300 ^ WORD_W'(a + i);
         if (a + i < DEPTH)
         begin
            mem[a + i] = wd;
            exp_q.push_back({6'h00, ADDR_W'(a + i), wd});
         end
         @(posedge clock_i);
         wr_valid_i <= 1'b1;
         wr_data_i <= wd;
         do @(negedge clock_i); while (wr_ready !== 1'b1);
         @(posedge clock_i);
         wr_valid_i <= 1'b0;
      end
      end_frame();
      chk(32'(got_q.size()), 32'(exp_q.size()));
      while (exp_q.size() > 0 && got_q.size() > 0)
         chk(got_q.pop_front(), exp_q.pop_front());
      exp_q = {};
      got_q = {};
   endtask

   task automatic do_read(input int a, input int n);
      int ea;
      send_cmd(1'b1, a, n);
      for (int i = 0; i < n; i++)
      begin
         ea = (a + i < DEPTH) ? a + i : DEPTH - 1;
         do @(negedge clock_i); while (rd_valid !== 1'b1);
         chk({16'h0000, rd_data}, {16'h0000, mem[ea]});
      end
      end_frame();
   endtask

   // ************************************************************
   // Stimulus
   // ************************************************************
   always @(posedge clock_i)
      if (dv === 1'b1)
         got_q.push_back({6'h00, da, dd});

   initial
   begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end

   // Twenty thousand cycles, several times the expected run
   initial
   begin
      #1000000;
      n_mismatch++;
      tally_and_finish();
   end

   initial
   begin
      rst_n_i = 1'b1;
      cmd_valid_i = 1'b0;
      cmd_read_i = 1'b0;
      cmd_addr_i = 10'h000;
      cmd_count_i = 8'h00;
      wr_valid_i = 1'b0;
      wr_data_i = 16'h0000;
      strap_lo = 1'b0;
      strap_hi = 1'b0;
      // A clean falling edge after time zero, so every asynchronous
      // reset process sees it however the simulator starts them
      #1 rst_n_i = 1'b0;
      repeat (10) @(posedge clock_i);
      rst_n_i <= 1'b1;
      for (int s = 0; s < 4; s++)
      begin
         @(posedge clock_i);
         strap_lo <= s[0];
         strap_hi <= s[1];
         repeat (5) @(negedge clock_i);
         chk({25'h0, i2c_addr}, {25'h0, I2C_ADDR_BASE, s[1], s[0]});
      end
      do_write(10'h020, 1);
      do_write(10'h010, 3);
      do_write(10'h3FE, 3);
      do_read(10'h020, 1);
      do_read(10'h010, 3);
      do_read(10'h3FE, 4);
      tally_and_finish();
   end
endmodule
`default_nettype wire
